// >>> design/old_top.sv
// Off-state open-load probe sequencer for four high-side outputs with status words.
// Assumes serial decoding is upstream: writes arrive as a pulse in the core clock,
// while chip select and the analog comparators come straight from pins.
`timescale 1ns/1ps
module old_top
  import old_pkg::*;
#(
  parameter int unsigned N_CH           = NUM_CH,
  parameter int unsigned TIMEOUT_CYCLES = PROBE_CYCLES,
  parameter int unsigned DEGLITCH_COUNT = DEGLITCH_CYCLES
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_clk_en,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_probe_wr,
  input  wire logic [N_CH-1:0]   i_offstate_probe_enable,
  input  wire logic [N_CH-1:0]   i_probe_current_threshold,
  input  wire logic [N_CH-1:0]   i_battery_short,
  input  wire logic [N_CH-1:0]   i_overtemp_shutdown_flag,
  input  wire logic [N_CH-1:0]   i_overtemp_warning_flag,
  input  wire logic [N_CH-1:0]   i_onstate_open_flag,
  input  wire logic [N_CH*3-1:0] i_overcurrent_code,
  input  wire logic              i_undervoltage_event,
  input  wire logic              i_charge_pump_fault_flag,
  input  wire logic              i_device_fault,
  input  wire logic              i_overload,
  input  wire logic [N_CH-1:0]   i_status_read,
  output logic [N_CH-1:0]        o_probe_drive,
  output logic [N_CH-1:0]        o_offstate_probe_enable,
  output logic [N_CH-1:0]        o_offstate_open_flag,
  output logic [N_CH-1:0]        o_channel_quick_flag,
  output logic                   o_global_open_load_flag,
  output logic                   o_global_overload_flag,
  output logic                   o_global_device_flag,
  output logic [N_CH-1:0]        o_output_state_bit,
  output logic                   o_undervoltage_flag,
  output logic [N_CH*8-1:0]      o_channel_status
);
  logic            rst_s1_q;
  logic            rst_s2_q;
  logic            cs_s1_q;
  logic            cs_s2_q;
  logic            cs_s3_q;
  logic [N_CH-1:0] thr_s1_q;
  logic [N_CH-1:0] thr_s2_q;
  logic [N_CH-1:0] bat_s1_q;
  logic [N_CH-1:0] bat_s2_q;
  logic [N_CH-1:0] ots_s1_q;
  logic [N_CH-1:0] ots_s2_q;
  logic [2:0]      flt_s1_q;
  logic [2:0]      flt_s2_q;
  logic            cs_rise;
  logic            fault_any;
  logic [N_CH-1:0] busy;
  logic [N_CH-1:0] drive;
  logic [N_CH-1:0] done_p;
  logic [N_CH-1:0] open_p;
  logic [N_CH-1:0] en_q;
  logic [N_CH-1:0] open_q;
  logic            ovl_q;
  logic            dev_q;

  // Reset release is synchronised so every channel leaves reset on the same edge
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Pin inputs pass two flops; cs_s3_q gives the edge without touching stage one
  always_ff @(posedge i_clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      thr_s1_q <= '0;
      thr_s2_q <= '0;
      bat_s1_q <= '0;
      bat_s2_q <= '0;
      ots_s1_q <= '0;
      ots_s2_q <= '0;
      flt_s1_q <= '0;
      flt_s2_q <= '0;
    end else if (i_clk_en) begin
      cs_s1_q  <= i_chip_select_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      thr_s1_q <= i_probe_current_threshold;
      thr_s2_q <= thr_s1_q;
      bat_s1_q <= i_battery_short;
      bat_s2_q <= bat_s1_q;
      ots_s1_q <= i_overtemp_shutdown_flag;
      ots_s2_q <= ots_s1_q;
      flt_s1_q <= {i_undervoltage_event, i_charge_pump_fault_flag, 1'b0};
      flt_s2_q <= flt_s1_q;
    end
  end

  assign cs_rise   = cs_s2_q & ~cs_s3_q;
  assign fault_any = flt_s2_q[2] | flt_s2_q[1];

  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    old_channel #(
      .TIMEOUT_CYCLES (TIMEOUT_CYCLES),
      .DEGLITCH_COUNT (DEGLITCH_COUNT)
    ) u_ch (
      .i_clock         (i_clock),
      .i_rst_n         (rst_s2_q),
      .i_enable        (i_clk_en),
      .i_start         (cs_rise & en_q[c]),
      .i_threshold_hit (thr_s2_q[c]),
      .i_fault         (fault_any | ots_s2_q[c]),
      .o_busy          (busy[c]),
      .o_drive_on      (drive[c]),
      .o_done_pulse    (done_p[c]),
      .o_open_pulse    (open_p[c])
    );
  end

  // Enable bits: writes blocked while busy, cleared by the channel's done pulse when its probe ends
  always_ff @(posedge i_clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      en_q <= PROBE_EN_RESET;
    end else if (i_clk_en) begin
      for (int c = 0; c < N_CH; c++) begin
        if (done_p[c]) begin
          en_q[c] <= 1'b0;
        end else if (i_probe_wr && !busy[c] && !(cs_rise && en_q[c])) begin
          en_q[c] <= i_offstate_probe_enable[c];
        end
      end
    end
  end

  // Open flags: a new result in the read cycle wins over the clear
  always_ff @(posedge i_clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      open_q <= '0;
    end else if (i_clk_en) begin
      for (int c = 0; c < N_CH; c++) begin
        if (open_p[c]) begin
          open_q[c] <= 1'b1;
        end else if (i_status_read[c]) begin
          open_q[c] <= 1'b0;
        end
      end
    end
  end

  // Global overload and device flags stay set until any channel word is read while no channel quick flag is set
  always_ff @(posedge i_clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      ovl_q <= 1'b0;
      dev_q <= 1'b0;
    end else if (i_clk_en) begin
      if (i_overload || old_any(ots_s2_q)) begin
        ovl_q <= 1'b1;
      end else if (!old_any(o_channel_quick_flag) && old_any(i_status_read)) begin
        ovl_q <= 1'b0;
      end
      if (i_device_fault || fault_any) begin
        dev_q <= 1'b1;
      end else if (!old_any(o_channel_quick_flag) && old_any(i_status_read)) begin
        dev_q <= 1'b0;
      end
    end
  end

  // Registered outputs; overcurrent codes feed only the quick flags and status words here, with no synchroniser
  always_ff @(posedge i_clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      o_probe_drive           <= '0;
      o_offstate_probe_enable <= '0;
      o_offstate_open_flag    <= '0;
      o_channel_quick_flag    <= '0;
      o_global_open_load_flag <= 1'b0;
      o_global_overload_flag  <= 1'b0;
      o_global_device_flag    <= 1'b0;
      o_output_state_bit      <= '0;
      o_undervoltage_flag     <= 1'b0;
      o_channel_status        <= '0;
    end else if (i_clk_en) begin
      o_probe_drive           <= drive;
      // A finishing channel is masked so its enable and its drive fall on the same edge
      o_offstate_probe_enable <= en_q & ~done_p;
      o_offstate_open_flag    <= open_q;
      o_global_open_load_flag <= old_any(open_q) | old_any(i_onstate_open_flag);
      o_global_overload_flag  <= ovl_q;
      o_global_device_flag    <= dev_q;
      o_output_state_bit      <= bat_s2_q;
      o_undervoltage_flag     <= flt_s2_q[2];
      for (int c = 0; c < N_CH; c++) begin
        o_channel_quick_flag[c] <= |i_overcurrent_code[c*3 +: 3] | i_overtemp_warning_flag[c]
                                   | ots_s2_q[c] | i_onstate_open_flag[c] | open_q[c];
        o_channel_status[c*8 +: 8] <= {1'b0, ots_s2_q[c], i_overtemp_warning_flag[c],
                                       i_overcurrent_code[c*3 +: 3], i_onstate_open_flag[c], open_q[c]};
      end
    end
  end
endmodule : old_top

// >>> inc/old_pkg.sv
// Constants and types shared by the off-state open-load probe sequencer.
// Assumes a 125 MHz core clock; no bus, all control and status are ports.
package old_pkg;
  localparam int unsigned NUM_CH            = 4;
  localparam real         CLK_MHZ           = 125.0;
  localparam real         PROBE_TIMEOUT_MS  = 1.2;   // Typical, window 0.9 to 1.5 ms
  localparam real         PROBE_TIMEOUT_MIN_MS = 0.9;
  localparam real         PROBE_TIMEOUT_MAX_MS = 1.5;
  localparam real         FAULT_DEGLITCH_US = 3.3;
  localparam int unsigned PROBE_CYCLES      = int'(PROBE_TIMEOUT_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned DEGLITCH_CYCLES   = int'($floor(FAULT_DEGLITCH_US * CLK_MHZ));
  localparam int unsigned CNT_W             = 18;
  localparam int unsigned DGL_W             = 10;
  localparam logic [3:0]  PROBE_EN_RESET    = 4'h0;
  // Channel status word layout, bit positions; 8 to 10 lie beyond the 8-bit word
  localparam int unsigned ST_OFF_OPEN       = 0;
  localparam int unsigned ST_ON_OPEN        = 1;
  localparam int unsigned ST_OC0            = 2;
  localparam int unsigned ST_OTW            = 5;
  localparam int unsigned ST_OTS            = 6;
  localparam int unsigned ST_OPEN_GLOBAL    = 8;
  localparam int unsigned ST_OVL_GLOBAL     = 9;
  localparam int unsigned ST_DEV_GLOBAL     = 10;

  typedef enum logic [3:0] {
    OLD_IDLE  = 4'b0001,
    OLD_PROBE = 4'b0010,
    OLD_ABORT = 4'b0100,
    OLD_DONE  = 4'b1000
  } old_state_t;

  function automatic logic old_any(input logic [NUM_CH-1:0] v);
    return |v;
  endfunction : old_any
endpackage : old_pkg

// >>> design/old_channel.sv
// One channel of the off-state open-load probe: timer and fault-abort deglitch.
// Assumes start, threshold and fault inputs are already synchronous to i_clock.
`timescale 1ns/1ps
module old_channel
  import old_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES  = PROBE_CYCLES,
  parameter int unsigned DEGLITCH_COUNT  = DEGLITCH_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_enable,
  input  wire logic i_start,
  input  wire logic i_threshold_hit,
  input  wire logic i_fault,
  output logic      o_busy,
  output logic      o_drive_on,
  output logic      o_done_pulse,
  output logic      o_open_pulse
);
  old_state_t       state_q;
  logic [CNT_W-1:0] timer_q;
  logic [DGL_W-1:0] dgl_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q      <= OLD_IDLE;
      timer_q      <= '0;
      dgl_q        <= '0;
      o_drive_on   <= 1'b0;
      o_done_pulse <= 1'b0;
      o_open_pulse <= 1'b0;
    end else if (i_enable) begin
      o_done_pulse <= 1'b0;
      o_open_pulse <= 1'b0;
      case (state_q)
        OLD_IDLE: begin
          if (i_start) begin
            state_q    <= OLD_PROBE;
            timer_q    <= CNT_W'(TIMEOUT_CYCLES - 1);
            o_drive_on <= 1'b1;
          end
        end
        OLD_PROBE: begin
          if (i_fault) begin
            state_q <= OLD_ABORT;
            dgl_q   <= DGL_W'(DEGLITCH_COUNT - 1);
          end else if (i_threshold_hit) begin
            state_q      <= OLD_DONE;
            o_drive_on   <= 1'b0;
            o_done_pulse <= 1'b1;
          end else if (timer_q == '0) begin
            state_q      <= OLD_DONE;
            o_drive_on   <= 1'b0;
            o_done_pulse <= 1'b1;
            o_open_pulse <= 1'b1;
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        OLD_ABORT: begin
          // Output stays on through the deglitch, then turns off whether or not the fault is still present
          if (dgl_q == '0) begin
            state_q      <= OLD_DONE;
            o_drive_on   <= 1'b0;
            o_done_pulse <= 1'b1;
          end else begin
            dgl_q <= dgl_q - 1'b1;
          end
        end
        OLD_DONE: state_q <= OLD_IDLE;
        default:  state_q <= OLD_IDLE;
      endcase
    end
  end

  assign o_busy = (state_q == OLD_PROBE) || (state_q == OLD_ABORT);
endmodule : old_channel

// >>> tb/old_asserts.sv
// Port checker for the off-state probe sequencer, bound into old_top.
// Assumes faults are held longer than the abort deglitch.
`timescale 1ns/1ps
module old_asserts
  import old_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = PROBE_CYCLES,
  parameter int unsigned DEGLITCH_COUNT = DEGLITCH_CYCLES
) (
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_chip_select_n,
  input wire logic [3:0]  i_battery_short,
  input wire logic        i_undervoltage_event,
  input wire logic [3:0]  i_status_read,
  input wire logic [3:0]  o_probe_drive,
  input wire logic [3:0]  o_offstate_probe_enable,
  input wire logic [3:0]  o_offstate_open_flag,
  input wire logic [3:0]  o_channel_quick_flag,
  input wire logic        o_global_open_load_flag,
  input wire logic [3:0]  o_output_state_bit,
  input wire logic [31:0] o_channel_status
);
  localparam int DG = DEGLITCH_COUNT + 6;
  logic [19:0] run_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) run_q <= 20'h0;
    else run_q <= o_probe_drive[0] ? run_q + 20'h1 : 20'h0;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_probe_start: assert property ($rose(o_probe_drive[0]) |->
    $past(o_offstate_probe_enable[0]) && $past(i_chip_select_n)) else $error("drive rose unasked");
  a_probe_span: assert property (o_probe_drive[0] |-> run_q <= TIMEOUT_CYCLES)
    else $error("probe ran past timeout");
  a_off_clears: assert property ($fell(o_probe_drive[0]) |-> !o_offstate_probe_enable[0])
    else $error("enable left set after drive off");
  a_open_after: assert property ($rose(o_offstate_open_flag[0]) |-> $past(o_probe_drive[0]) ||
    $past(o_probe_drive[0], 2) || $past(o_probe_drive[0], 3)) else $error("open flag without probe");
  a_quick_open: assert property ((o_offstate_open_flag & ~o_channel_quick_flag) == 4'h0)
    else $error("quick flag misses open");
  a_global_open: assert property (|o_offstate_open_flag |-> o_global_open_load_flag)
    else $error("global open flag missing");
  a_status_open: assert property ({o_channel_status[24], o_channel_status[16], o_channel_status[8],
    o_channel_status[0]} == o_offstate_open_flag) else $error("status open bit differs");
  a_open_holds: assert property (o_offstate_open_flag[0] && !i_status_read[0] &&
    !$past(i_status_read[0]) |=> o_offstate_open_flag[0]) else $error("open flag dropped unread");
  a_fault_off: assert property (i_undervoltage_event [*8] |-> ##[0:DG] o_probe_drive == 4'h0)
    else $error("fault did not stop probes");
  a_short_live: assert property (($stable(i_battery_short) && !i_undervoltage_event) [*4] |->
    o_output_state_bit == i_battery_short) else $error("short bit not live");
  c_open: cover property ($rose(o_offstate_open_flag[0]));
  c_thresh: cover property ($fell(o_probe_drive[1]));
  c_read: cover property (i_status_read[0] && o_offstate_open_flag[0]);
endmodule : old_asserts
bind old_top old_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .DEGLITCH_COUNT(DEGLITCH_COUNT)) i_old_asserts (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_chip_select_n(i_chip_select_n), .i_battery_short(i_battery_short),
  .i_undervoltage_event(i_undervoltage_event), .i_status_read(i_status_read), .o_probe_drive(o_probe_drive),
  .o_offstate_probe_enable(o_offstate_probe_enable), .o_offstate_open_flag(o_offstate_open_flag),
  .o_channel_quick_flag(o_channel_quick_flag), .o_global_open_load_flag(o_global_open_load_flag),
  .o_output_state_bit(o_output_state_bit), .o_channel_status(o_channel_status));

// >>> tb/old_host_model.sv
// Host controller model: serial frames on chip select, decoded write and read pulses.
// Assumes the serial word is decoded upstream into a one-cycle write pulse.
`timescale 1ns/1ps
module old_host_model (
  input  wire logic i_clock,
  output logic       o_chip_select_n,
  output logic       o_sclk,
  output logic       o_probe_wr,
  output logic [3:0] o_probe_enable,
  output logic [3:0] o_status_read
);
  initial begin
    {o_sclk, o_probe_wr, o_probe_enable, o_status_read} = '0;
    o_chip_select_n = 1'b1;
  end
  // Link clock only runs inside a frame
  task automatic write_en(input logic [3:0] mask);
    @(negedge i_clock);
    o_chip_select_n = 1'b0;
    repeat (32) #32 o_sclk = ~o_sclk;
    @(negedge i_clock);
    o_probe_wr = 1'b1;
    o_probe_enable = mask;
    @(negedge i_clock);
    o_probe_wr = 1'b0;
    o_probe_enable = ~mask;
    o_chip_select_n = 1'b1;
  endtask : write_en
  task automatic read(input logic [3:0] ch);
    @(negedge i_clock);
    o_status_read = ch;
    @(negedge i_clock);
    o_status_read = 4'h0;
  endtask : read
endmodule : old_host_model

// >>> tb/old_top_bench.sv
// Self-checking bench for old_top with the host model on the serial side.
// Assumes a shortened probe timeout and deglitch through parameters.
`timescale 1ns/1ps
module old_top_bench;
  localparam int TO = 400;
  logic        clk, rst_n, cs_n, sclk, wr, uv, gopen, govl, gdev, undervoltage_flag, clk_en, charge_pump_fault_flag, devf, ovl;
  logic [3:0]  en, thr, bsh, overtemp_shutdown_flag, overtemp_warning_flag, onopen, rd, drive, en_o, open, quick, obit;
  logic [11:0] oc;
  logic [31:0] status;
  int          errors, n_tests, run, last;
  old_host_model i_old_host_model (.i_clock(clk), .o_chip_select_n(cs_n), .o_sclk(sclk),
    .o_probe_wr(wr), .o_probe_enable(en), .o_status_read(rd));
  old_top #(.TIMEOUT_CYCLES(TO), .DEGLITCH_COUNT(4)) i_old_top (.i_clock(clk), .i_rst_n(rst_n),
    .i_clk_en(clk_en), .i_chip_select_n(cs_n), .i_probe_wr(wr), .i_offstate_probe_enable(en),
    .i_probe_current_threshold(thr), .i_battery_short(bsh), .i_overtemp_shutdown_flag(overtemp_shutdown_flag),
    .i_overtemp_warning_flag(overtemp_warning_flag), .i_onstate_open_flag(onopen), .i_overcurrent_code(oc),
    .i_undervoltage_event(uv), .i_charge_pump_fault_flag(charge_pump_fault_flag), .i_device_fault(devf),
    .i_overload(ovl), .i_status_read(rd), .o_probe_drive(drive), .o_offstate_probe_enable(en_o),
    .o_offstate_open_flag(open), .o_channel_quick_flag(quick), .o_global_open_load_flag(gopen),
    .o_global_overload_flag(govl), .o_global_device_flag(gdev), .o_output_state_bit(obit),
    .o_undervoltage_flag(undervoltage_flag), .o_channel_status(status));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    run <= drive[0] ? run + 1 : 0;
    if (!drive[0] && run != 0) last <= run;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_drv(input int ch, input logic lvl, output int n);
    n = 0;
    while (drive[ch] !== lvl && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_drv
  task automatic t_timeout();
    int n;
    chk("enable at reset", en_o, 4'h0);
    i_old_host_model.write_en(4'h5);
    wait_drv(0, 1'b1, n);
    chk("drive", drive, 4'h5);
    i_old_host_model.write_en(4'h0);
    chk("busy enable", en_o, 4'h5);
    wait_drv(0, 1'b0, n);
    chk("enable off", en_o, 4'h0);
    repeat (3) @(negedge clk);
    // The run length is only recorded on the edge after the drive falls
    chk("length", last >= TO && last <= TO + 1, 1);
    chk("open", open, 4'h5);
    chk("quick", quick, 4'h5);
    chk("global", gopen, 1'b1);
    chk("status", {status[24], status[16], status[8], status[0]}, 4'h5);
    $display("done t_timeout");
  endtask : t_timeout
  task automatic t_read();
    repeat (20) @(negedge clk);
    chk("held", open, 4'h5);
    // A read strobe while the clock enable is low must not be taken
    clk_en = 1'b0;
    i_old_host_model.read(4'h1);
    @(negedge clk);
    clk_en = 1'b1;
    repeat (2) @(negedge clk);
    chk("frozen read", open, 4'h5);
    i_old_host_model.read(4'h1);
    repeat (3) @(negedge clk);
    chk("after read", open, 4'h4);
    chk("global kept", gopen, 1'b1);
    i_old_host_model.read(4'h4);
    repeat (3) @(negedge clk);
    chk("all read", {open, 3'h0, gopen}, 8'h00);
    $display("done t_read");
  endtask : t_read
  task automatic t_thresh();
    int n;
    i_old_host_model.write_en(4'h2);
    wait_drv(1, 1'b1, n);
    thr = 4'h2;
    wait_drv(1, 1'b0, n);
    chk("early off", n < 8, 1);
    thr = 4'h0;
    repeat (4) @(negedge clk);
    chk("no flag", {en_o, open, quick}, 12'h000);
    $display("done t_thresh");
  endtask : t_thresh
  task automatic t_fault();
    int n;
    logic [3:0] want;
    for (int k = 0; k < 3; k++) begin
      // Undervoltage, then charge pump, then a shutdown on the probed channel itself
      want = (k == 0) ? 4'h6 : (k == 1) ? 4'h4 : 4'h9;
      i_old_host_model.write_en(4'h8);
      wait_drv(3, 1'b1, n);
      {overtemp_shutdown_flag[3], charge_pump_fault_flag, uv} = 3'b001 << k;
      wait_drv(3, 1'b0, n);
      chk("abort", n <= 12, 1);
      chk("fault flags", {govl, gdev, undervoltage_flag, status[30]}, want);
      repeat (TO) @(negedge clk);
      chk("no open", open, 4'h0);
      {overtemp_shutdown_flag, charge_pump_fault_flag, uv} = '0;
      repeat (4) @(negedge clk);
      i_old_host_model.read(4'h8);
      repeat (3) @(negedge clk);
      chk("flags cleared", {govl, gdev, undervoltage_flag}, 3'h0);
    end
    $display("done t_fault");
  endtask : t_fault
  task automatic t_flags();
    oc = 12'h010;
    overtemp_warning_flag = 4'h4;
    onopen = 4'h8;
    bsh = 4'ha;
    repeat (6) @(negedge clk);
    chk("quick or", quick, 4'he);
    chk("status", status, 32'h0220_0800);
    chk("short", obit, 4'ha);
    {devf, ovl} = 2'b11;
    repeat (4) @(negedge clk);
    {devf, ovl} = 2'b00;
    // Quick flags are still set, so this read must leave the global flags up
    i_old_host_model.read(4'h2);
    repeat (3) @(negedge clk);
    chk("global held", {govl, gdev}, 2'b11);
    $display("done t_flags");
  endtask : t_flags
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  initial begin
    {rst_n, thr, bsh, overtemp_shutdown_flag, overtemp_warning_flag, onopen, oc, uv, charge_pump_fault_flag, devf, ovl, run, last, errors, n_tests} = '0;
    clk_en = 1'b1;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_timeout();
    t_read();
    t_thresh();
    t_fault();
    t_flags();
    end_sim();
  end
endmodule : old_top_bench
